// [fos_output_stage.sv]
// Two-channel output stage: alarm switching and analog scaling behind AXI4-Lite.
// Assumes i_meas_valid pulses once per measurement, at least 50 clocks apart,
// with i_flow, i_total and i_part valid in that cycle, all on i_clk.
//
// Contract
// - Two outputs, each with its own source and output type selection.
// - Limit mode turns the switch on when the value exceeds the upper threshold.
// - Limit switch stays on until value drops below threshold minus hysteresis.
// - Window mode turns the switch on when value lies outside the band.
// - Window mode leaves the on state only inside band shrunk by hysteresis.
// - Normally-open polarity is default; output active above the threshold.
// - Normally-closed polarity inverts the output, active inside the window.
// - Lower threshold is ignored by the limit function, used only by window.
// - Thresholds and values compare as signed numbers.
// - Delay count above one postpones switching; zero or one switches at once.
// - Delay direction picks rising crossings, falling crossings, or both.
// - Switch only after that many consecutive measurements on the new side.
// - Driver sinks, sources, or push-pulls driving both levels.
// - Current output maps value linearly from 0 or 4 mA to 20 mA.
// - Voltage output maps value linearly from 0 or 2 V to 10 V.
// - Full-scale point resets to range end; accepted only above range start.
// - Start point may be programmed anywhere inside the measuring range.
`timescale 1ns/1ps
`default_nettype none

module fos_output_stage
   import fos_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [ADDR_W-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_meas_valid,
   input wire logic signed [31:0] i_flow,
   input wire logic signed [31:0] i_total,
   input wire logic signed [31:0] i_part,
   output logic [NUM_CH-1:0] o_sw_level,
   output logic [NUM_CH-1:0] o_sw_source_en,
   output logic [NUM_CH-1:0] o_sw_sink_en,
   output logic [CODE_W-1:0] o_analog_code0,
   output logic [CODE_W-1:0] o_analog_code1
);

   typedef struct packed {
      logic [CFG_W-1:0] cfg;
      logic signed [31:0] thr_hi;
      logic signed [31:0] thr_lo;
      logic [31:0] hyst;
      logic [CNT_W-1:0] delay;
      logic signed [31:0] an_lo;
      logic signed [31:0] an_hi;
      logic active;
      logic [CNT_W-1:0] run;
      logic level;
      logic src_en;
      logic sink_en;
      logic [CODE_W-1:0] code;
   } fos_chan_t;

   typedef struct packed {
      fos_chan_t [NUM_CH-1:0] ch;
      logic aw_rdy;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_rdy;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic b_vld;
      logic [1:0] b_resp;
      logic ar_rdy;
      logic r_vld;
      logic [31:0] r_data;
      logic [1:0] r_resp;
   } fos_state_t;

   fos_state_t s_ff;
   fos_state_t nxt_s;
   logic [NUM_CH-1:0] div_done;
   logic [CODE_W-1:0] div_quot [NUM_CH];

   // Address decode: {hit, channel, word index}
   function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
      decode = {(a[7:6] == 2'h0) && (a[1:0] == 2'h0), a[ADDR_CH_BIT], a[4:2]};
   endfunction : decode

   function automatic logic [31:0] read_reg(input fos_chan_t c, input logic [2:0] idx);
      read_reg = 32'h0000_0000;
      unique case (idx)
         IDX_CFG: read_reg = 32'(c.cfg);
         IDX_THR_HI: read_reg = c.thr_hi;
         IDX_THR_LO: read_reg = c.thr_lo;
         IDX_HYST: read_reg = c.hyst;
         IDX_DELAY: read_reg = 32'(c.delay);
         IDX_AN_START: read_reg = c.an_lo;
         IDX_AN_FULL: read_reg = c.an_hi;
         IDX_STATUS: begin
            read_reg[STS_LEVEL_BIT] = c.level;
            read_reg[STS_ACTIVE_BIT] = c.active;
            read_reg[STS_CODE_LSB +: CODE_W] = c.code;
         end
      endcase
   endfunction : read_reg

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         merge[8*b +: 8] = strb[b] ? d[8*b +: 8] : old[8*b +: 8];
      end
   endfunction : merge

   function automatic logic in_range(input logic signed [31:0] v);
      in_range = (v >= MEAS_RANGE_START) && (v <= MEAS_RANGE_END);
   endfunction : in_range

   function automatic logic signed [33:0] sel_value(input logic [1:0] src,
                                                   input logic signed [31:0] f,
                                                   input logic signed [31:0] t,
                                                   input logic signed [31:0] p);
      unique case (fos_src_t'(src))
         SRC_TOTAL: sel_value = 34'(t);
         SRC_PART: sel_value = 34'(p);
         default: sel_value = 34'(f);
      endcase
   endfunction : sel_value

   function automatic logic is_analog(input logic [2:0] ot);
      is_analog = (ot <= 3'(OT_VOLT_2_10));
   endfunction : is_analog

   // Start code and span of each analog variant
   function automatic logic [CODE_W-1:0] start_code(input logic [2:0] ot);
      unique case (fos_otype_t'(ot))
         OT_CUR_4_20: start_code = CUR_LIVE_ZERO_UA;
         OT_CUR_0_20: start_code = CUR_ZERO_UA;
         OT_VOLT_2_10: start_code = VOLT_LIVE_ZERO_MV;
         default: start_code = VOLT_ZERO_MV;
      endcase
   endfunction : start_code

   function automatic logic [CODE_W-1:0] span_code(input logic [2:0] ot);
      if (ot <= 3'(OT_CUR_0_20)) begin
         span_code = CUR_FULL_UA - start_code(ot);
      end else begin
         span_code = VOLT_FULL_MV - start_code(ot);
      end
   endfunction : span_code

   // One scaler per channel, started on each measurement of an analog output
   for (genvar g = 0; g < NUM_CH; g++) begin : g_scale
      logic signed [33:0] v;
      logic signed [33:0] lo;
      logic signed [33:0] hi;
      logic signed [33:0] den;
      logic signed [33:0] off;
      logic [31:0] num;
      logic [2:0] ot;

      assign ot = s_ff.ch[g].cfg[CFG_TYPE_LSB +: 3];
      assign v = sel_value(s_ff.ch[g].cfg[CFG_SRC_LSB +: 2], i_flow, i_total, i_part);
      assign lo = 34'(s_ff.ch[g].an_lo);
      assign hi = 34'(s_ff.ch[g].an_hi);
      assign den = hi - lo;
      assign off = v - lo;
      // Clamp below the start point and above full scale; a start point at or
      // past full scale degenerates to a step at the full-scale value
      assign num = (den <= 34'sh0) ? ((v >= hi) ? 32'h0000_0001 : 32'h0000_0000) :
                   (v <= lo) ? 32'h0000_0000 :
                   (v >= hi) ? den[31:0] : off[31:0];

      fos_scale_div u_div (
         .i_clk(i_clk),
         .i_reset_n(i_reset_n),
         .i_start(i_meas_valid && is_analog(ot)),
         .i_num(num),
         .i_den((den <= 34'sh0) ? 32'h0000_0001 : den[31:0]),
         .i_span(span_code(ot)),
         .o_done(div_done[g]),
         .o_quot(div_quot[g])
      );
   end

   always_comb begin
      logic [4:0] dec;
      logic [31:0] wv;
      logic signed [33:0] v;
      logic signed [33:0] hi;
      logic signed [33:0] lo;
      logic signed [33:0] hy;
      logic [2:0] ot;
      logic win;
      logic tgt;
      logic dly_on;
      logic [1:0] dir;
      logic [1:0] drv;
      dec = decode(s_ff.aw_addr);
      wv = 32'h0000_0000;
      v = 34'sh0;
      hi = 34'sh0;
      lo = 34'sh0;
      hy = 34'sh0;
      ot = 3'h0;
      win = 1'b0;
      tgt = 1'b0;
      dly_on = 1'b0;
      dir = 2'h0;
      drv = 2'h0;
      nxt_s = s_ff;

      // Write path: address and data accepted in either order
      if (s_ff.aw_rdy && i_awvalid) begin
         nxt_s.aw_rdy = 1'b0;
         nxt_s.aw_have = 1'b1;
         nxt_s.aw_addr = i_awaddr;
      end
      if (s_ff.w_rdy && i_wvalid) begin
         nxt_s.w_rdy = 1'b0;
         nxt_s.w_have = 1'b1;
         nxt_s.w_data = i_wdata;
         nxt_s.w_strb = i_wstrb;
      end
      if (s_ff.aw_have && s_ff.w_have && !s_ff.b_vld) begin
         nxt_s.aw_have = 1'b0;
         nxt_s.w_have = 1'b0;
         nxt_s.b_vld = 1'b1;
         nxt_s.b_resp = RESP_OKAY;
         wv = merge(read_reg(s_ff.ch[dec[3]], dec[2:0]), s_ff.w_data, s_ff.w_strb);
         if (!dec[4]) begin
            nxt_s.b_resp = RESP_SLVERR;
         end else begin
            unique case (dec[2:0])
               IDX_CFG: nxt_s.ch[dec[3]].cfg = wv[CFG_W-1:0];
               IDX_THR_HI: nxt_s.ch[dec[3]].thr_hi = wv;
               IDX_THR_LO: nxt_s.ch[dec[3]].thr_lo = wv;
               IDX_HYST: nxt_s.ch[dec[3]].hyst = wv;
               IDX_DELAY: nxt_s.ch[dec[3]].delay = wv[CNT_W-1:0];
               IDX_AN_START: begin
                  if (in_range(wv)) begin
                     nxt_s.ch[dec[3]].an_lo = wv;
                  end else begin
                     nxt_s.b_resp = RESP_SLVERR;
                  end
               end
               IDX_AN_FULL: begin
                  if (in_range(wv) && ($signed(wv) > MEAS_RANGE_START)) begin
                     nxt_s.ch[dec[3]].an_hi = wv;
                  end else begin
                     nxt_s.b_resp = RESP_SLVERR;
                  end
               end
               IDX_STATUS: nxt_s.b_resp = RESP_OKAY;
            endcase
         end
      end
      if (s_ff.b_vld && i_bready) begin
         nxt_s.b_vld = 1'b0;
         nxt_s.aw_rdy = 1'b1;
         nxt_s.w_rdy = 1'b1;
      end

      // Read path
      if (s_ff.ar_rdy && i_arvalid) begin
         nxt_s.ar_rdy = 1'b0;
         nxt_s.r_vld = 1'b1;
         nxt_s.r_data = decode(i_araddr) >= 5'h10 ?
                        read_reg(s_ff.ch[i_araddr[ADDR_CH_BIT]], i_araddr[4:2]) : 32'h0000_0000;
         nxt_s.r_resp = decode(i_araddr) >= 5'h10 ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_ff.r_vld && i_rready) begin
         nxt_s.r_vld = 1'b0;
         nxt_s.ar_rdy = 1'b1;
      end

      // Per-channel switching and analog update
      for (int c = 0; c < NUM_CH; c++) begin
         ot = s_ff.ch[c].cfg[CFG_TYPE_LSB +: 3];
         win = s_ff.ch[c].cfg[CFG_FUNC_BIT] == FN_WINDOW;
         dir = s_ff.ch[c].cfg[CFG_DIR_LSB +: 2];
         drv = s_ff.ch[c].cfg[CFG_DRV_LSB +: 2];
         v = sel_value(s_ff.ch[c].cfg[CFG_SRC_LSB +: 2], i_flow, i_total, i_part);
         hi = 34'(s_ff.ch[c].thr_hi);
         lo = 34'(s_ff.ch[c].thr_lo);
         hy = {2'b00, s_ff.ch[c].hyst};
         if (ot != 3'(OT_ALARM)) begin
            nxt_s.ch[c].active = 1'b0;
            nxt_s.ch[c].run = '0;
         end else if (i_meas_valid) begin
            if (!s_ff.ch[c].active) begin
               tgt = (v > hi) || (win && (v < lo));
            end else if (!win) begin
               tgt = !(v < hi - hy);
            end else begin
               tgt = !((v < hi - hy) && (v > lo + hy));
            end
            // Delay applies only to the crossing directions selected
            dly_on = (s_ff.ch[c].delay != '0) &&
                     (tgt ? (dir != 2'(DIR_FALL)) : (dir != 2'(DIR_RISE)));
            if (tgt == s_ff.ch[c].active) begin
               nxt_s.ch[c].run = '0;
            end else if (!dly_on || (s_ff.ch[c].run + 16'h0001 >= s_ff.ch[c].delay)) begin
               nxt_s.ch[c].active = tgt;
               nxt_s.ch[c].run = '0;
            end else begin
               nxt_s.ch[c].run = s_ff.ch[c].run + 16'h0001;
            end
         end
         // Polarity applied after the decision so hysteresis stays the same
         nxt_s.ch[c].level = (ot == 3'(OT_ALARM)) &&
                             (nxt_s.ch[c].active ^ s_ff.ch[c].cfg[CFG_POL_BIT]);
         nxt_s.ch[c].src_en = nxt_s.ch[c].level && (drv != 2'(DRV_SINK));
         nxt_s.ch[c].sink_en = (ot == 3'(OT_ALARM)) &&
                               ((drv == 2'(DRV_SINK)) ? nxt_s.ch[c].level :
                                (drv == 2'(DRV_PUSH_PULL)) ? !nxt_s.ch[c].level : 1'b0);
         if (!is_analog(ot)) begin
            nxt_s.ch[c].code = '0;
         end else if (div_done[c]) begin
            nxt_s.ch[c].code = start_code(ot) + div_quot[c];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_ff <= '0;
         s_ff.aw_rdy <= 1'b1;
         s_ff.w_rdy <= 1'b1;
         s_ff.ar_rdy <= 1'b1;
         for (int c = 0; c < NUM_CH; c++) begin
            s_ff.ch[c].cfg <= RST_CFG;
            s_ff.ch[c].thr_hi <= RST_THR;
            s_ff.ch[c].thr_lo <= RST_THR;
            s_ff.ch[c].hyst <= RST_HYST;
            s_ff.ch[c].delay <= RST_DELAY;
            s_ff.ch[c].an_lo <= MEAS_RANGE_START;
            s_ff.ch[c].an_hi <= MEAS_RANGE_END;
         end
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_awready = s_ff.aw_rdy;
   assign o_wready = s_ff.w_rdy;
   assign o_bvalid = s_ff.b_vld;
   assign o_bresp = s_ff.b_resp;
   assign o_arready = s_ff.ar_rdy;
   assign o_rvalid = s_ff.r_vld;
   assign o_rdata = s_ff.r_data;
   assign o_rresp = s_ff.r_resp;
   assign o_analog_code0 = s_ff.ch[0].code;
   assign o_analog_code1 = s_ff.ch[1].code;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_pins
      assign o_sw_level[g] = s_ff.ch[g].level;
      assign o_sw_source_en[g] = s_ff.ch[g].src_en;
      assign o_sw_sink_en[g] = s_ff.ch[g].sink_en;
   end

endmodule : fos_output_stage

`default_nettype wire

// [fos_pkg.sv]
// Output stage constants: register map, fields, resets, encodings, scaling.
// Assumes a 32-bit AXI4-Lite register bus and signed 32-bit measured values.
package fos_pkg;

   localparam int NUM_CH = 2;
   localparam int ADDR_W = 8;
   localparam int CODE_W = 16;
   localparam int CNT_W = 16;
   localparam int CFG_W = 11;

   // Register word index inside one channel block; channel is address bit 5
   localparam logic [2:0] IDX_CFG = 3'h0;
   localparam logic [2:0] IDX_THR_HI = 3'h1;
   localparam logic [2:0] IDX_THR_LO = 3'h2;
   localparam logic [2:0] IDX_HYST = 3'h3;
   localparam logic [2:0] IDX_DELAY = 3'h4;
   localparam logic [2:0] IDX_AN_START = 3'h5;
   localparam logic [2:0] IDX_AN_FULL = 3'h6;
   localparam logic [2:0] IDX_STATUS = 3'h7;
   localparam int ADDR_CH_BIT = 5;

   // Configuration word fields
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_TYPE_LSB = 2;
   localparam int CFG_FUNC_BIT = 5;
   localparam int CFG_POL_BIT = 6;
   localparam int CFG_DIR_LSB = 7;
   localparam int CFG_DRV_LSB = 9;

   // Status word fields
   localparam int STS_LEVEL_BIT = 0;
   localparam int STS_ACTIVE_BIT = 1;
   localparam int STS_CODE_LSB = 16;

   typedef enum logic [1:0] {SRC_FLOW, SRC_TOTAL, SRC_PART} fos_src_t;
   typedef enum logic [2:0] {OT_CUR_4_20, OT_CUR_0_20, OT_VOLT_0_10, OT_VOLT_2_10,
                             OT_ALARM, OT_PULSE, OT_FREQ} fos_otype_t;
   typedef enum logic {FN_LIMIT, FN_WINDOW} fos_func_t;
   typedef enum logic {POL_NO, POL_NC} fos_pol_t;
   typedef enum logic [1:0] {DIR_RISE, DIR_FALL, DIR_BOTH} fos_dir_t;
   typedef enum logic [1:0] {DRV_SINK, DRV_SOURCE, DRV_PUSH_PULL} fos_drv_t;

   // Measuring range of the sensor, in the units of the measured value
   localparam logic signed [31:0] MEAS_RANGE_START = 32'sh0000_0000;
   localparam logic signed [31:0] MEAS_RANGE_END = 32'sh0001_86a0;

   // Reset: flow source, alarm, limit, normally open, delay both ways, push-pull
   localparam logic [CFG_W-1:0] RST_CFG = 11'h510;
   localparam logic signed [31:0] RST_THR = 32'sh0000_0000;
   localparam logic [31:0] RST_HYST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] RST_DELAY = 16'h0000;

   // Analog codes: current in microamps, voltage in millivolts
   localparam logic [CODE_W-1:0] CUR_FULL_UA = 16'h4e20;
   localparam logic [CODE_W-1:0] CUR_LIVE_ZERO_UA = 16'h0fa0;
   localparam logic [CODE_W-1:0] CUR_ZERO_UA = 16'h0000;
   localparam logic [CODE_W-1:0] VOLT_FULL_MV = 16'h2710;
   localparam logic [CODE_W-1:0] VOLT_LIVE_ZERO_MV = 16'h07d0;
   localparam logic [CODE_W-1:0] VOLT_ZERO_MV = 16'h0000;

   localparam logic [5:0] DIV_STEPS = 6'h30;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fos_pkg

// [fos_scale_div.sv]
// Scaler for one analog channel: quotient of num * span / den, bit-serial.
// Assumes num <= den, so the quotient never exceeds span; start is a pulse.
`timescale 1ns/1ps
`default_nettype none

module fos_scale_div
   import fos_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire logic [31:0] i_num,
   input wire logic [31:0] i_den,
   input wire logic [CODE_W-1:0] i_span,
   output logic o_done,
   output logic [CODE_W-1:0] o_quot
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] steps;
      logic [32:0] rem;
      logic [47:0] acc;
      logic [31:0] den;
      logic [CODE_W-1:0] quot;
   } fos_div_t;

   fos_div_t s_ff;
   fos_div_t nxt_s;
   logic [32:0] trial;

   // Restoring division, one bit a cycle: small area for a fixed latency
   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      trial = {s_ff.rem[31:0], s_ff.acc[47]};
      if (i_start) begin
         nxt_s.busy = 1'b1;
         nxt_s.steps = 6'h00;
         nxt_s.rem = 33'h0_0000_0000;
         nxt_s.acc = 48'(i_num) * 48'(i_span);
         nxt_s.den = i_den;
      end else if (s_ff.busy) begin
         nxt_s.acc = {s_ff.acc[46:0], 1'b0};
         if (trial >= {1'b0, s_ff.den}) begin
            nxt_s.rem = trial - {1'b0, s_ff.den};
            nxt_s.acc[0] = 1'b1;
         end else begin
            nxt_s.rem = trial;
         end
         nxt_s.steps = s_ff.steps + 6'h01;
         if (s_ff.steps == DIV_STEPS - 6'h01) begin
            nxt_s.busy = 1'b0;
            nxt_s.done = 1'b1;
            nxt_s.quot = nxt_s.acc[CODE_W-1:0];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_done = s_ff.done;
   assign o_quot = s_ff.quot;

endmodule : fos_scale_div

`default_nettype wire

// [fos_load_model.sv]
// Load on one switching output: pull resistor, two transistors.
// Assumes enables straight from the stage; PULL is the pull level.
`timescale 1ns/1ps
`default_nettype none
module fos_load_model #(
   parameter logic PULL = 1'b1
) (
   input wire logic i_source_en,
   input wire logic i_sink_en,
   output logic o_pin,
   output logic o_clash
);
   // An enabled transistor drives the pin, source before sink; otherwise the resistor pulls it
   always_comb begin
      o_clash = i_source_en && i_sink_en;
      o_pin = i_source_en ? 1'b1 : (i_sink_en ? 1'b0 : PULL);
   end
endmodule : fos_load_model
`default_nettype wire

// [fos_output_stage_asserts.sv]
// Checker: bus handshakes and switch driver enables.
// Sees only the stage's ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module fos_output_stage_chk
   import fos_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic [NUM_CH-1:0] o_sw_level,
   input wire logic [NUM_CH-1:0] o_sw_source_en,
   input wire logic [NUM_CH-1:0] o_sw_sink_en
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   sequence s_wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_rd_taken;
      i_arvalid && o_arready;
   endsequence
   a_rd_answer: assert property (s_rd_taken |=> o_rvalid)
      else $error("read answer missing");
   a_rd_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   a_rd_block: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while busy");
   a_wr_answer: assert property (s_wr_taken |-> ##[1:3] o_bvalid)
      else $error("write answer missing");
   a_wr_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   a_wr_block: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while busy");
   a_full_refuse: assert property (s_wr_taken ##0 (i_awaddr[4:0] == 5'h18 &&
      i_awaddr[7:6] == 2'h0 && i_wdata == 32'h0) |-> ##[1:3] (o_bvalid && o_bresp == RESP_SLVERR))
      else $error("bad full scale accepted");
   a_drv_excl: assert property ((o_sw_source_en & o_sw_sink_en) == '0)
      else $error("both drivers on");
   a_src_level: assert property ((o_sw_source_en & ~o_sw_level) == '0)
      else $error("source on while output off");
endmodule : fos_output_stage_chk
bind fos_output_stage fos_output_stage_chk chk_u (.*);
`default_nettype wire

// [fos_output_stage_bench.sv]
// Bench: bus master, measurement driver, queue monitor.
// Assumes the checker bound, a pulled-up load per pin.
`timescale 1ns/1ps
`default_nettype none
module fos_output_stage_bench
   import fos_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
   logic arv = 1'b0, rre = 1'b0, mv = 1'b0, mv_d = 1'b0;
   logic awr, wrdy, bv, arr, rv;
   logic [1:0] br, rr, lvl, sen, ken, pin;
   logic [7:0] awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, rdat;
   logic signed [31:0] fl = 32'h0, tot = 32'h0, prt = 32'h0;
   logic [15:0] c0, c1;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [4:0] sq[$];
   logic [15:0] aq[$];
   logic [1:0] drv[2] = '{2'h2, 2'h0};
   logic [9:0] dx[3] = '{10'h008, 10'h1fe, 10'h00e};
   int n_fail = 0, check_count = 0, seed = 11914, wt = 0;
   int hi[2] = '{-100, 1000}, lo[2] = '{1000, 0}, hy[2] = '{50, 100};
   int fx[12] = '{-150, -99, -140, -151, -200, 500, 1001, 950, 800, -1, 50, 150};
   int dv[10] = '{-5, 5, 5, -5, 5, 5, 5, -5, -5, -5};
   always #12.5 clk = ~clk;
   fos_output_stage dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_awvalid(awv), .o_awready(awr),
      .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hf),
      .o_bvalid(bv), .i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
      .i_araddr(ara), .o_rvalid(rv), .i_rready(rre), .o_rdata(rdat), .o_rresp(rr),
      .i_meas_valid(mv), .i_flow(fl), .i_total(tot), .i_part(prt), .o_sw_level(lvl),
      .o_sw_source_en(sen), .o_sw_sink_en(ken), .o_analog_code0(c0), .o_analog_code1(c1));
   fos_load_model ld0_u (.i_source_en(sen[0]), .i_sink_en(ken[0]), .o_pin(pin[0]), .o_clash());
   fos_load_model ld1_u (.i_source_en(sen[1]), .i_sink_en(ken[1]), .o_pin(pin[1]), .o_clash());
   task automatic tally(input logic [33:0] g, e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : tally
   task automatic cmp_rd(input logic [33:0] g, e);
      tally(g, e);
   endtask : cmp_rd
   task automatic cmp_b(input logic [1:0] g, e);
      tally(34'(g), 34'(e));
   endtask : cmp_b
   task automatic cmp_sw(input logic [3:0] g, e);
      tally(34'(g), 34'(e));
   endtask : cmp_sw
   task automatic cmp_an(input logic [15:0] g, e);
      tally(34'(g), 34'(e));
   endtask : cmp_an
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   function automatic logic [7:0] ra(input int c, input logic [2:0] x);
      return 8'((c << ADDR_CH_BIT) + (x << 2));
   endfunction : ra
   function automatic logic [2:0] sw_exp(input logic [1:0] d, input logic l);
      return {d != 2'h0 && l, d == 2'h0 ? l : (d == 2'h2 && !l), d == 2'h0 ? !l : l | d == 2'h1};
   endfunction : sw_exp
   function automatic logic step(input logic a, w, input int v, h, b, y);
      if (w) return a ? !(b + y < v && v < h - y) : (v > h || v < b);
      return a ? (v >= h - y) : (v > h);
   endfunction : step
   function automatic logic [15:0] an_exp(input int ty, v);
      longint s0, fs;
      s0 = (ty == 0) ? CUR_LIVE_ZERO_UA : ((ty == 3) ? VOLT_LIVE_ZERO_MV : 16'h0);
      fs = (ty < 2) ? CUR_FULL_UA : VOLT_FULL_MV;
      v = (v < 20000) ? 20000 : ((v > 60000) ? 60000 : v);
      return 16'(s0 + (v - 20000) * (fs - s0) / 40000);
   endfunction : an_exp
   task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge clk);
      rq.push_back(e);
      arv <= 1'b1;
      ara <= a;
      rre <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rre <= 1'b0;
   endtask : axi_rd
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
      @(posedge clk);
      bq.push_back(e);
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      awa <= a;
      wd <= d;
      do @(posedge clk); while (!(awr && wrdy));
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge clk); while (!bv);
      bre <= 1'b0;
   endtask : axi_wr
   // Spaced past one conversion so each pulse yields a code
   task automatic meas(input int f, t, ch, an, input logic [15:0] e);
      @(posedge clk);
      if (an) aq.push_back(e);
      else sq.push_back({ch[0], e[0], sw_exp(drv[ch], e[0])});
      fl <= f;
      tot <= t;
      prt <= ~f;
      mv <= 1'b1;
      @(posedge clk);
      mv <= 1'b0;
      repeat (52) @(posedge clk);
   endtask : meas
   always @(posedge clk) begin : mon_b
      logic [4:0] n;
      mv_d <= mv;
      wt <= mv ? 51 : (wt > 0 ? wt - 1 : 0);
      if (rv && rre) cmp_rd({rr, rdat}, rq.pop_front());
      if (bv && bre) cmp_b(br, bq.pop_front());
      if (mv_d && sq.size() > 0) begin
         n = sq.pop_front();
         cmp_sw({lvl[n[4]], sen[n[4]], ken[n[4]], pin[n[4]]}, n[3:0]);
      end
      if (wt == 1 && aq.size() > 0) cmp_an(c1, 16'h0000);
      if (wt == 1 && aq.size() > 0) cmp_an(c0, aq.pop_front());
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      wrap_up;
   end
   initial begin : main_b
      int v;
      logic act;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      axi_rd(ra(0, IDX_CFG), {RESP_OKAY, 21'h0, RST_CFG});
      axi_rd(ra(1, IDX_AN_FULL), {RESP_OKAY, MEAS_RANGE_END});
      axi_rd(8'h40, {RESP_SLVERR, 32'h0});
      axi_wr(8'h44, 32'h1, RESP_SLVERR);
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         axi_wr(ra(k, IDX_CFG), k ? 32'h070 : 32'h410);
         axi_wr(ra(k, IDX_THR_HI), 32'(hi[k]));
         axi_wr(ra(k, IDX_THR_LO), 32'(lo[k]));
         axi_wr(ra(k, IDX_HYST), 32'(hy[k]));
         act = 1'b0;
         for (int i = 0; i < 28; i++) begin
            v = (i < 12) ? fx[i] : $random(seed) % 1200;
            act = step(act, k[0], v, hi[k], lo[k], hy[k]);
            meas(v, 0, k, 0, 16'(act ^ k[0]));
         end
         $display("test switch %0d done", k);
      end
      axi_wr(ra(0, IDX_THR_HI), 32'h0);
      axi_wr(ra(0, IDX_HYST), 32'h0);
      for (int d = 0; d < 3; d++) begin
         axi_wr(ra(0, IDX_CFG), 32'h410 | 32'(d << 7));
         axi_wr(ra(0, IDX_DELAY), 32'h3);
         for (int i = 0; i < 10; i++) meas(dv[i], 0, 0, 0, 16'(dx[d][9-i]));
      end
      $display("test delay done");
      axi_wr(ra(0, IDX_AN_START), 32'h4e20);
      axi_wr(ra(0, IDX_AN_FULL), 32'hea60);
      axi_wr(ra(0, IDX_AN_FULL), 32'h0, RESP_SLVERR);
      axi_wr(ra(0, IDX_AN_START), 32'h186a1, RESP_SLVERR);
      axi_rd(ra(0, IDX_AN_FULL), {RESP_OKAY, 32'hea60});
      for (int ty = 0; ty < 4; ty++) begin
         axi_wr(ra(0, IDX_CFG), 32'(ty << 2) | 32'(ty == 1));
         for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? {$random(seed)} % 100000 : ((i == 1) ? 10000 : 70000);
            meas(ty == 1 ? 99 : v, v, 0, 1, an_exp(ty, v));
         end
      end
      $display("test analog done");
      wrap_up;
   end
endmodule : fos_output_stage_bench
`default_nettype wire
